// *** hw/core_map.svh ***
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH
`define IC_TRAP_CM_PARITY 16'h8000
`define IC_TRAP_RESET_BTN 16'h8001
`define IC_TRAP_DM_PARITY 16'h8002
`define IC_TRAP_POWER_ON 16'h8003
`define IC_PROM_BASE_BIT 15
`define CW_PARITY_BIT 23
`define CW_HIGH_LSB 16
`define ALU_OP_LSB 16
`define DST_LSB 12
`define SRCB_LSB 8
`define SRCA_LSB 4
`define SUB_LSB 0
`define REG_ZERO 4'h0
`define REG_FILE_BASE 4'h8
`define REG_ARITH_ST 4'h1
`define REG_PHASE_ST 4'h2
`define REG_XFER 4'h3
`define REG_RDHI 4'h4
`define REG_RDLO 4'h5
`define REG_PCH 4'h6
`define REG_PCL 4'h7
`define ST_CARRY_BIT 0
`define ST_ZERO_BIT 1
`define ST_PERIPH_BIT 2
`define PROM_SLOW_PHASES 2'h2
`endif

// *** hw/core_pkg.sv ***
`default_nettype none
package core_pkg;
	typedef enum logic [2:0] {
		OP_ALU = 3'h0,
		OP_JUMP = 3'h1,
		OP_DM_READ = 3'h2,
		OP_DM_WRITE = 3'h3,
		OP_CM_READ = 3'h4,
		OP_CM_WRITE = 3'h5,
		OP_PERIPH_IN = 3'h6,
		OP_PERIPH_OUT = 3'h7
	} opcode_t;
	typedef enum logic [2:0] {
		FN_ADD = 3'h0,
		FN_SUB = 3'h1,
		FN_AND = 3'h2,
		FN_OR = 3'h3,
		FN_XOR = 3'h4,
		FN_PASS_A = 3'h5,
		FN_ADD_CARRY = 3'h6,
		FN_PASS_B = 3'h7
	} alu_fn_t;
	typedef enum logic [1:0] {
		PH_FETCH = 2'b00,
		PH_EXEC = 2'b01,
		PH_WAIT = 2'b10
	} phase_t;
endpackage
`default_nettype wire

// *** hw/core_alu.sv ***
`default_nettype none
module core_alu #(
	parameter int WIDTH = 8
) (
	// Operands
	input wire logic [WIDTH-1:0] i_bus_a,
	input wire logic [WIDTH-1:0] i_bus_b,
	input wire logic i_carry,
	input wire core_pkg::alu_fn_t i_fn,
	// Result
	output logic [WIDTH-1:0] o_bus_c,
	output logic o_carry
);
	logic [WIDTH:0] wide;
	always_comb begin
		wide = '0;
		unique case (i_fn)
			core_pkg::FN_ADD: wide = {1'b0, i_bus_a} + {1'b0, i_bus_b};
			core_pkg::FN_SUB: wide = {1'b0, i_bus_a} - {1'b0, i_bus_b};
			core_pkg::FN_AND: wide = {1'b0, i_bus_a & i_bus_b};
			core_pkg::FN_OR: wide = {1'b0, i_bus_a | i_bus_b};
			core_pkg::FN_XOR: wide = {1'b0, i_bus_a ^ i_bus_b};
			core_pkg::FN_PASS_A: wide = {1'b0, i_bus_a};
			core_pkg::FN_ADD_CARRY: wide = {1'b0, i_bus_a} + {1'b0, i_bus_b} + {{WIDTH{1'b0}}, i_carry};
			core_pkg::FN_PASS_B: wide = {1'b0, i_bus_b};
		endcase
		o_bus_c = wide[WIDTH-1:0];
		o_carry = wide[WIDTH];
	end
endmodule
`default_nettype wire

// *** hw/core_sync.sv ***
`default_nettype none
module core_sync (
	// Clock
	input wire logic i_mclk,
	// Asynchronous level
	input wire logic i_async,
	// Synchronised level
	output logic o_sync
);
	logic [1:0] stages;
	// The first stage is read only by the second, to keep metastability contained.
	always_ff @(posedge i_mclk) begin
		stages <= {stages[0], i_async};
	end
	assign o_sync = stages[1];
endmodule
`default_nettype wire

// *** hw/micro_cpu_core.sv ***
`default_nettype none
`include "core_map.svh"
module micro_cpu_core #(
	parameter int DM_ADDR_W = 17,
	parameter int CM_ADDR_W = 16
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Trap sources from pins
	input wire logic i_power_on_reset,
	input wire logic i_reset_button,
	// Control memory
	output logic [CM_ADDR_W-1:0] o_cm_addr,
	output logic o_cm_rd,
	output logic o_cm_wr,
	output logic [23:0] o_cm_wdata,
	input wire logic [23:0] i_cm_rdata,
	output logic o_bootstrap_prom_select,
	// Data memory
	output logic [DM_ADDR_W-1:0] o_dm_addr,
	output logic o_dm_rd,
	output logic o_dm_wr,
	output logic [15:0] o_dm_wdata,
	output logic [1:0] o_dm_byte_en,
	input wire logic [15:0] i_dm_rdata,
	input wire logic i_data_mem_parity_error,
	// Peripheral
	output logic o_periph_strobe,
	output logic o_periph_dir_out,
	output logic [7:0] o_periph_wdata,
	input wire logic [7:0] i_periph_rdata,
	input wire logic i_periph_ready,
	// Status
	output logic o_ctrl_mem_parity_error,
	output logic [7:0] o_arith_io_status,
	output logic [7:0] o_phase_mode_status
);
	typedef struct packed {
		core_pkg::phase_t phase;
		logic [1:0] slow;
		logic [15:0] icount;
		logic [23:0] ireg;
		logic [7:0][7:0] file_regs;
		logic [7:0] arith_io_status_reg;
		logic [7:0] phase_mode_status_reg;
		logic [7:0] xfer_reg;
		logic [7:0] read_data_high_reg;
		logic [7:0] read_data_low_reg;
		logic [15:0] pc;
		logic pc_bank;
		logic cm_perr;
		logic por_seen;
	} state_t;

	state_t st;
	state_t next_st;
	logic por_sync;
	logic btn_sync;
	logic dm_perr_sync;
	logic [7:0] bus_a;
	logic [7:0] bus_b;
	logic [7:0] bus_c;
	logic alu_carry;
	core_pkg::opcode_t opcode;
	logic [3:0] src_a;
	logic [3:0] src_b;
	logic [3:0] dst;
	logic [3:0] sub;
	logic in_prom;

	// Pins from outside the clock domain pass two flops first.
	core_sync sync_por (.i_mclk(i_mclk), .i_async(i_power_on_reset), .o_sync(por_sync));
	core_sync sync_btn (.i_mclk(i_mclk), .i_async(i_reset_button), .o_sync(btn_sync));
	core_sync sync_dmp (.i_mclk(i_mclk), .i_async(i_data_mem_parity_error), .o_sync(dm_perr_sync));

	assign opcode = core_pkg::opcode_t'(st.ireg[22:20]);
	assign src_a = st.ireg[`SRCA_LSB+:4];
	assign src_b = st.ireg[`SRCB_LSB+:4];
	assign dst = st.ireg[`DST_LSB+:4];
	assign sub = st.ireg[`SUB_LSB+:4];
	assign in_prom = st.icount[`IC_PROM_BASE_BIT];

	function automatic logic [7:0] read_src(input state_t s, input logic [3:0] sel);
		logic [7:0] v;
		v = 8'h00;
		if (sel[3]) begin
			v = s.file_regs[sel[2:0]];
		end else begin
			unique case (sel)
				`REG_ZERO: v = 8'h00;
				`REG_ARITH_ST: v = s.arith_io_status_reg;
				`REG_PHASE_ST: v = s.phase_mode_status_reg;
				`REG_XFER: v = s.xfer_reg;
				`REG_RDHI: v = s.read_data_high_reg;
				`REG_RDLO: v = s.read_data_low_reg;
				`REG_PCH: v = s.pc[15:8];
				`REG_PCL: v = s.pc[7:0];
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction

	always_comb begin
		bus_a = read_src(st, src_a);
		bus_b = read_src(st, src_b);
	end

	core_alu #(.WIDTH(8)) alu (
		.i_bus_a(bus_a),
		.i_bus_b(bus_b),
		.i_carry(st.arith_io_status_reg[`ST_CARRY_BIT]),
		.i_fn(core_pkg::alu_fn_t'(st.ireg[`ALU_OP_LSB+:3])),
		.o_bus_c(bus_c),
		.o_carry(alu_carry)
	);

	always_comb begin
		next_st = st;
		o_cm_rd = 1'b0;
		o_cm_wr = 1'b0;
		o_dm_rd = 1'b0;
		o_dm_wr = 1'b0;
		o_periph_strobe = 1'b0;
		o_periph_dir_out = 1'b0;
		o_cm_addr = st.icount[CM_ADDR_W-1:0];
		unique case (st.phase)
			core_pkg::PH_FETCH: begin
				o_cm_rd = 1'b1;
				// PROM is slow, so a fetch from it holds the address two extra cycles for half speed.
				if (in_prom && st.slow != `PROM_SLOW_PHASES) begin
					next_st.slow = st.slow + 2'h1;
				end else begin
					next_st.slow = 2'h0;
					next_st.ireg = i_cm_rdata;
					next_st.phase = core_pkg::PH_EXEC;
				end
			end
			core_pkg::PH_EXEC: begin
				next_st.phase = core_pkg::PH_FETCH;
				if (^st.ireg == 1'b0) begin
					next_st.cm_perr = 1'b1;
					next_st.icount = `IC_TRAP_CM_PARITY;
				end else begin
					next_st.cm_perr = 1'b0;
					next_st.icount = st.icount + 16'h0001;
					// All destination writes land here, so operands saw the old values.
					unique case (opcode)
						core_pkg::OP_ALU: begin
							if (dst[3]) begin
								next_st.file_regs[dst[2:0]] = bus_c;
							end else begin
								unique case (dst)
									`REG_ZERO: ;
									`REG_ARITH_ST: next_st.arith_io_status_reg = bus_c;
									`REG_PHASE_ST: next_st.phase_mode_status_reg = bus_c;
									`REG_XFER: next_st.xfer_reg = bus_c;
									`REG_RDHI: next_st.read_data_high_reg = bus_c;
									`REG_RDLO: next_st.read_data_low_reg = bus_c;
									`REG_PCH: next_st.pc[15:8] = bus_c;
									`REG_PCL: next_st.pc[7:0] = bus_c;
									default: ;
								endcase
							end
							if (dst != `REG_ARITH_ST) begin
								next_st.arith_io_status_reg[`ST_CARRY_BIT] = alu_carry;
								next_st.arith_io_status_reg[`ST_ZERO_BIT] = (bus_c == 8'h00);
							end
						end
						core_pkg::OP_JUMP: begin
							next_st.icount = {bus_a, bus_b};
						end
						core_pkg::OP_DM_READ: begin
							o_dm_rd = 1'b1;
							if (sub[0]) begin
								next_st.read_data_high_reg = i_dm_rdata[15:8];
							end
							if (sub[1]) begin
								next_st.read_data_low_reg = i_dm_rdata[7:0];
							end
						end
						core_pkg::OP_DM_WRITE: begin
							o_dm_wr = 1'b1;
						end
						core_pkg::OP_CM_READ: begin
							o_cm_rd = 1'b1;
							o_cm_addr = st.pc[CM_ADDR_W-1:0];
							next_st.xfer_reg = i_cm_rdata[`CW_HIGH_LSB+:8];
							next_st.read_data_high_reg = i_cm_rdata[15:8];
							next_st.read_data_low_reg = i_cm_rdata[7:0];
						end
						core_pkg::OP_CM_WRITE: begin
							o_cm_wr = 1'b1;
							o_cm_addr = st.pc[CM_ADDR_W-1:0];
						end
						core_pkg::OP_PERIPH_IN: begin
							o_periph_strobe = 1'b1;
							if (i_periph_ready) begin
								next_st.xfer_reg = i_periph_rdata;
							end else begin
								next_st.icount = st.icount;
								next_st.phase = core_pkg::PH_EXEC;
							end
							next_st.arith_io_status_reg[`ST_PERIPH_BIT] = i_periph_ready;
						end
						core_pkg::OP_PERIPH_OUT: begin
							o_periph_strobe = 1'b1;
							o_periph_dir_out = 1'b1;
							if (!i_periph_ready) begin
								next_st.icount = st.icount;
								next_st.phase = core_pkg::PH_EXEC;
							end
							next_st.arith_io_status_reg[`ST_PERIPH_BIT] = i_periph_ready;
						end
					endcase
				end
			end
			default: begin
				next_st.phase = core_pkg::PH_FETCH;
			end
		endcase
		// Traps override whatever the instruction chose; power-on has priority.
		if (dm_perr_sync) begin
			next_st.icount = `IC_TRAP_DM_PARITY;
			next_st.phase = core_pkg::PH_FETCH;
			next_st.slow = 2'h0;
		end
		if (btn_sync) begin
			next_st.icount = `IC_TRAP_RESET_BTN;
			next_st.phase = core_pkg::PH_FETCH;
			next_st.slow = 2'h0;
		end
		next_st.por_seen = por_sync;
		if (por_sync) begin
			next_st.icount = `IC_TRAP_POWER_ON;
			next_st.phase = core_pkg::PH_FETCH;
			next_st.slow = 2'h0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st <= '0;
			st.icount <= `IC_TRAP_POWER_ON;
		end else begin
			st <= next_st;
		end
	end

	// Writes store the Data Memory Input byte, with the bank bit picking the lane.
	always_comb begin
		o_dm_addr = {st.pc, st.pc_bank};
		o_dm_wdata = {st.xfer_reg, st.xfer_reg};
		o_dm_byte_en = {st.pc_bank, ~st.pc_bank};
	end

	assign o_cm_wdata = {~^{st.xfer_reg[6:0], st.read_data_high_reg, st.read_data_low_reg},
		st.xfer_reg[6:0], st.read_data_high_reg, st.read_data_low_reg};
	assign o_bootstrap_prom_select = in_prom;
	assign o_periph_wdata = st.xfer_reg;
	assign o_ctrl_mem_parity_error = st.cm_perr;
	assign o_arith_io_status = st.arith_io_status_reg;
	assign o_phase_mode_status = st.phase_mode_status_reg;
endmodule
`default_nettype wire

// *** dv/micro_cpu_core_monitor.sv ***
`default_nettype none
module micro_cpu_core_monitor #(
	parameter int DM_ADDR_W = 17,
	parameter int CM_ADDR_W = 16
) (
	// Clock, reset and trap pins
	input wire logic i_mclk, i_rst, i_power_on_reset, i_reset_button, i_data_mem_parity_error,
	// Control memory
	input wire logic [CM_ADDR_W-1:0] o_cm_addr,
	input wire logic o_cm_rd, o_cm_wr, o_bootstrap_prom_select,
	input wire logic [23:0] o_cm_wdata, i_cm_rdata,
	// Data memory
	input wire logic [DM_ADDR_W-1:0] o_dm_addr,
	input wire logic o_dm_rd, o_dm_wr,
	input wire logic [15:0] o_dm_wdata, i_dm_rdata,
	input wire logic [1:0] o_dm_byte_en,
	// Peripheral and status
	input wire logic o_periph_strobe, o_periph_dir_out, i_periph_ready, o_ctrl_mem_parity_error,
	input wire logic [7:0] o_periph_wdata, i_periph_rdata, o_arith_io_status, o_phase_mode_status
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] calm;
	logic quiet;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Trap pins pass a two-stage synchroniser, so sequencing is judged only well clear of them.
	always_ff @(posedge i_mclk) begin
		if (i_rst || i_power_on_reset || i_reset_button || i_data_mem_parity_error)
			calm <= 4'h0;
		else if (calm != 4'hf)
			calm <= calm + 4'h1;
	end
	assign quiet = calm[3];
	sequence fast_fetch;
		$rose(o_cm_rd) && !o_cm_addr[CM_ADDR_W-1] && quiet;
	endsequence
	sequence slow_fetch;
		$rose(o_cm_rd) && o_cm_addr[CM_ADDR_W-1] && quiet;
	endsequence
	chk_por_entry: assert property ($past(i_rst) |-> o_cm_rd && o_cm_addr == 16'h8003)
		else $error("First fetch after reset is not at the power-on entry.");
	chk_prom_slow_fetch: assert property (slow_fetch |=> (o_cm_rd && $stable(o_cm_addr))[*2] ##1 !o_cm_rd)
		else $error("Boot store fetch does not hold its address for three cycles.");
	chk_prom_select_high: assert property (slow_fetch |=> o_bootstrap_prom_select)
		else $error("Boot store select low during a fetch above the boundary.");
	chk_next_sequential: assert property (fast_fetch ##0 (i_cm_rdata[22:20] != 3'h1
		&& i_cm_rdata[22:21] != 2'h3 && ^i_cm_rdata)
		|-> ##2 (o_cm_rd && o_cm_addr == $past(o_cm_addr, 2) + 16'h1))
		else $error("Next fetch is not the following address.");
	chk_jump_target: assert property (fast_fetch ##0 (i_cm_rdata[22:20] == 3'h1 && i_cm_rdata[11:4] == 8'h00
		&& ^i_cm_rdata) |-> ##2 (o_cm_rd && o_cm_addr == 16'h0000))
		else $error("Jump through zero operands missed address zero.");
	chk_parity_trap: assert property (fast_fetch ##0 !(^i_cm_rdata)
		|-> ##2 (o_cm_rd && o_cm_addr == 16'h8000 && o_ctrl_mem_parity_error))
		else $error("Even parity word did not trap to the parity entry.");
	chk_button_trap: assert property ($rose(i_reset_button) |-> ##[2:8] (o_cm_rd && o_cm_addr == 16'h8001))
		else $error("Reset button did not reach the button entry.");
	chk_periph_hold: assert property (o_periph_strobe && !i_periph_ready
		|=> o_periph_strobe && $stable(o_periph_dir_out) && $stable(o_periph_wdata))
		else $error("Peripheral transfer dropped before it was accepted.");
	chk_dm_write_once: assert property (o_dm_wr |-> o_dm_wdata[15:8] == o_dm_wdata[7:0] && !o_dm_addr[0]
		##1 !o_dm_wr)
		else $error("Data write is malformed or lasts more than one cycle.");
	cover property (fast_fetch ##0 i_cm_rdata[22:20] == 3'h1);
	cover property (o_periph_strobe && !i_periph_ready ##1 i_periph_ready);
	cover property ($rose(o_ctrl_mem_parity_error));
endmodule
`default_nettype wire

// *** dv/core_mem_model.sv ***
`default_nettype none
module core_mem_model (
	// Clock
	input wire logic i_mclk,
	// Control memory side
	input wire logic [15:0] o_cm_addr,
	input wire logic o_cm_rd, o_cm_wr,
	input wire logic [23:0] o_cm_wdata,
	output logic [23:0] i_cm_rdata,
	// Data memory side
	input wire logic [16:0] o_dm_addr,
	input wire logic o_dm_rd, o_dm_wr,
	input wire logic [15:0] o_dm_wdata,
	input wire logic [1:0] o_dm_byte_en,
	output logic [15:0] i_dm_rdata,
	// Peripheral side
	input wire logic o_periph_strobe, o_periph_dir_out,
	input wire logic [7:0] in_byte,
	output logic [7:0] i_periph_rdata,
	output logic i_periph_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] cm [0:65535];
	logic [15:0] dm [0:65535];
	// Unselected lines show the inverse word so a stale value cannot pass for an answer.
	assign i_cm_rdata = o_cm_rd ? cm[o_cm_addr] : ~cm[o_cm_addr];
	assign i_dm_rdata = o_dm_rd ? dm[o_dm_addr[16:1]] : ~dm[o_dm_addr[16:1]];
	assign i_periph_rdata = (o_periph_strobe && !o_periph_dir_out) ? in_byte : ~in_byte;
	initial i_periph_ready = 1'b0;
	always @(posedge i_mclk) begin
		// Every transfer is stalled one cycle before it is accepted.
		i_periph_ready <= o_periph_strobe && !i_periph_ready;
		if (o_cm_wr)
			cm[o_cm_addr] <= o_cm_wdata;
		if (o_dm_wr && o_dm_byte_en[1])
			dm[o_dm_addr[16:1]][15:8] <= o_dm_wdata[15:8];
		if (o_dm_wr && o_dm_byte_en[0])
			dm[o_dm_addr[16:1]][7:0] <= o_dm_wdata[7:0];
	end
endmodule
`default_nettype wire

// *** dv/test_micro_cpu_core.sv ***
`default_nettype none
module test_micro_cpu_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk, i_rst, i_power_on_reset, i_reset_button, i_data_mem_parity_error;
	logic o_cm_rd, o_cm_wr, o_bootstrap_prom_select, o_dm_rd, o_dm_wr, o_periph_strobe, o_periph_dir_out;
	logic i_periph_ready, o_ctrl_mem_parity_error;
	logic [15:0] o_cm_addr, o_dm_wdata, i_dm_rdata, v, base;
	logic [23:0] o_cm_wdata, i_cm_rdata;
	logic [16:0] o_dm_addr;
	logic [1:0] o_dm_byte_en;
	logic [7:0] o_periph_wdata, i_periph_rdata, o_arith_io_status, o_phase_mode_status, d, in_byte;
	logic [33:0] notes[$];
	int err_total, total_checks, n;
	micro_cpu_core dut (.i_mclk, .i_rst, .i_power_on_reset, .i_reset_button, .o_cm_addr, .o_cm_rd, .o_cm_wr,
		.o_cm_wdata, .i_cm_rdata, .o_bootstrap_prom_select, .o_dm_addr, .o_dm_rd, .o_dm_wr, .o_dm_wdata,
		.o_dm_byte_en, .i_dm_rdata, .i_data_mem_parity_error, .o_periph_strobe, .o_periph_dir_out,
		.o_periph_wdata, .i_periph_rdata, .i_periph_ready, .o_ctrl_mem_parity_error, .o_arith_io_status,
		.o_phase_mode_status);
	core_mem_model mem (.i_mclk, .o_cm_addr, .o_cm_rd, .o_cm_wr, .o_cm_wdata, .i_cm_rdata, .o_dm_addr,
		.o_dm_rd, .o_dm_wr, .o_dm_wdata, .o_dm_byte_en, .i_dm_rdata, .o_periph_strobe, .o_periph_dir_out,
		.in_byte, .i_periph_rdata, .i_periph_ready);
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic put(input logic [15:0] a, input logic [2:0] op, fn, input logic [3:0] dst, b, sa);
		logic [23:0] w;
		w = {1'b0, op, 1'b0, fn, dst, b, sa, 4'h0};
		w[23] = ~^w[22:0];
		mem.cm[a] = w;
	endtask
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic take(input logic [33:0] seen);
		if (notes.size() == 0)
			check(seen, ~seen);
		else
			check(seen, notes.pop_front());
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		if (!i_rst && o_periph_strobe && o_periph_dir_out && i_periph_ready)
			take({26'h0, o_periph_wdata});
		if (!i_rst && o_dm_wr)
			take({1'b1, o_dm_addr, o_dm_wdata});
	end
	initial begin
		i_rst = 1'b1;
		i_power_on_reset = 1'b0;
		i_reset_button = 1'b0;
		i_data_mem_parity_error = 1'b0;
		err_total = 0;
		total_checks = 0;
		// The byte range keeps the two jump targets clear of each other and of address zero.
		d = (lfsr(8'h1e) & 8'h3f) | 8'h20;
		v = {lfsr(d), lfsr(lfsr(d))};
		in_byte = d;
		base = {8'h00, d};
		mem.dm[base] = v;
		put(16'h8003, 3'h6, 3'h0, 4'h0, 4'h0, 4'h0);
		put(16'h8004, 3'h0, 3'h5, 4'h8, 4'h0, 4'h3);
		put(16'h8005, 3'h0, 3'h0, 4'h9, 4'h8, 4'h8);
		put(16'h8006, 3'h0, 3'h5, 4'h0, 4'h0, 4'h3);
		put(16'h8007, 3'h0, 3'h7, 4'h3, 4'h0, 4'h0);
		put(16'h8008, 3'h7, 3'h0, 4'h0, 4'h0, 4'h0);
		put(16'h8009, 3'h0, 3'h5, 4'h3, 4'h0, 4'h9);
		put(16'h800a, 3'h7, 3'h0, 4'h0, 4'h0, 4'h0);
		put(16'h800b, 3'h1, 3'h0, 4'h0, 4'h8, 4'h0);
		put(base, 3'h0, 3'h5, 4'h7, 4'h0, 4'h8);
		put(base + 16'h1, 3'h2, 3'h0, 4'h0, 4'h0, 4'h0);
		// Two sub bits flip together, so the word keeps its odd parity.
		mem.cm[base + 16'h1] ^= 24'h000003;
		put(base + 16'h2, 3'h0, 3'h5, 4'h3, 4'h0, 4'h4);
		put(base + 16'h3, 3'h7, 3'h0, 4'h0, 4'h0, 4'h0);
		put(base + 16'h4, 3'h3, 3'h0, 4'h0, 4'h0, 4'h0);
		put(base + 16'h5, 3'h1, 3'h0, 4'h0, 4'h0, 4'h0);
		put(16'h0000, 3'h0, 3'h7, 4'h3, 4'h0, 4'h0);
		mem.cm[16'h0000] ^= 24'h800000;
		put(16'h8000, 3'h7, 3'h0, 4'h0, 4'h0, 4'h0);
		put(16'h8001, 3'h1, 3'h0, 4'h0, 4'h9, 4'h0);
		put({8'h00, d << 1}, 3'h1, 3'h0, 4'h0, 4'h9, 4'h0);
		notes.push_back({26'h0, 8'h00});
		notes.push_back({26'h0, (d << 1)});
		notes.push_back({26'h0, v[15:8]});
		notes.push_back({1'b1, base, 1'b0, v[15:8], v[15:8]});
		notes.push_back({26'h0, v[15:8]});
		repeat (8) @(posedge i_mclk);
		i_rst <= 1'b0;
		for (n = 0; n < 3000 && notes.size() != 0; n++)
			@(posedge i_mclk);
		for (n = n; n < 3100 && !(o_cm_rd && o_cm_addr == {8'h00, (d << 1)}); n++)
			@(posedge i_mclk);
		if (n >= 3000) begin
			err_total++;
			test_done;
		end
		check({33'h0, o_bootstrap_prom_select}, 34'h0);
		check({26'h0, o_phase_mode_status}, 34'h0);
		i_reset_button <= 1'b1;
		for (n = 0; n < 20 && !(o_cm_rd && o_cm_addr == 16'h8001); n++)
			@(posedge i_mclk);
		check({33'h0, n < 20}, 34'h1);
		check({33'h0, o_bootstrap_prom_select}, 34'h1);
		i_reset_button <= 1'b0;
		@(posedge i_mclk);
		test_done;
	end
endmodule
bind micro_cpu_core micro_cpu_core_monitor #(.DM_ADDR_W(DM_ADDR_W), .CM_ADDR_W(CM_ADDR_W)) mon (.i_mclk, .i_rst,
	.i_power_on_reset, .i_reset_button, .i_data_mem_parity_error, .o_cm_addr, .o_cm_rd, .o_cm_wr,
	.o_bootstrap_prom_select, .o_cm_wdata, .i_cm_rdata, .o_dm_addr, .o_dm_rd, .o_dm_wr, .o_dm_wdata,
	.i_dm_rdata, .o_dm_byte_en, .o_periph_strobe, .o_periph_dir_out, .i_periph_ready,
	.o_ctrl_mem_parity_error, .o_periph_wdata, .i_periph_rdata, .o_arith_io_status, .o_phase_mode_status);
`default_nettype wire
